// ===== logic/bridge_cfg.svh
`ifndef BRIDGE_CFG_SVH
`define BRIDGE_CFG_SVH
// ************************************************************
// clock and timing
// ************************************************************
`define CLK_HZ 125000000
`define RESTORE_HOLD_S 2
`define RESTORE_HOLD_CYC (`CLK_HZ * `RESTORE_HOLD_S)
`define MAX_BAUD 1000000
`define DEF_BAUD 115200
`define DEF_DIV (`CLK_HZ / `DEF_BAUD)
`define MIN_DIV (`CLK_HZ / `MAX_BAUD)
`define LED_BLINK_CYC 6250000
// ************************************************************
// register offsets
// ************************************************************
`define REG_CFG 4'h0
`define REG_BAUD 4'h1
`define REG_STAT 4'h2
`define REG_TXD 4'h3
`define REG_RXD 4'h4
`define REG_MODEM 4'h5
// ************************************************************
// cfg field positions and reset values
// ************************************************************
`define CFG_LEN_LSB 0
`define CFG_STOP_BIT 2
`define CFG_PAR_LSB 3
`define CFG_DEF 8'h03
`define MODEM_DEF 8'h00
`endif

// ===== logic/bridge_if.sv
`timescale 1ns/10ps
`default_nettype none
interface bridge_if;
    logic txd_dev;
    logic rxd_dev;
    logic cts_n;
    logic rts_n;
    logic dtr_n;
    logic dsr_n;
    logic dcd_n;
    logic ri_n;
    logic mode_sel;
    logic role_sel;
    logic flow_en_n;
    logic rst_n;
    logic tx_active_flag;
    logic led_n;
    logic restore_host_out;
    logic restore_host_oe_n;
    logic restore_dev_out;
    logic restore_dev_oe_n;
    // open-drain style resolution, released line pulls up
    wire restore_line = (!restore_host_oe_n && !restore_host_out) ? 1'b0 :
                        (!restore_dev_oe_n) ? restore_dev_out : 1'b1;
    modport dev (
        output txd_dev, rts_n, dtr_n, tx_active_flag, led_n, restore_dev_out, restore_dev_oe_n,
        input rxd_dev, cts_n, dsr_n, dcd_n, ri_n, mode_sel, role_sel, flow_en_n, rst_n,
        input restore_line
    );
    modport host (
        input txd_dev, rts_n, dtr_n, tx_active_flag, led_n, restore_line,
        output rxd_dev, cts_n, dsr_n, dcd_n, ri_n, mode_sel, role_sel, flow_en_n, rst_n,
        output restore_host_out, restore_host_oe_n
    );
endinterface : bridge_if
`default_nettype wire

// ===== logic/bridge_pkg.sv
package bridge_pkg;
    typedef enum logic [2:0] {PAR_NONE, PAR_ODD, PAR_EVEN, PAR_SPACE, PAR_MARK} parity_e;
    typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_e;
endpackage : bridge_pkg

// ===== logic/uart_bridge_dev.sv
`timescale 1ns/10ps
`default_nettype none
`include "bridge_cfg.svh"
module uart_bridge_dev #(
    parameter int HOLD_CYC = `RESTORE_HOLD_CYC,
    parameter int BLINK_CYC = `LED_BLINK_CYC
) (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    // pins
    bridge_if.dev PINS,
    // radio/usb side byte stream
    input wire logic LINK_UP_IN,
    input wire logic [7:0] RADIO_DATA_IN,
    input wire logic RADIO_VALID_IN,
    output logic [7:0] FWD_DATA_OUT,
    output logic FWD_VALID_OUT,
    output logic RESTORE_OUT,
    output logic CMD_MODE_OUT,
    output logic MASTER_SLAVE_OUT,
    output logic [7:0] CMD_BYTE_OUT,
    output logic CMD_VALID_OUT
);
    if (HOLD_CYC < 1 || BLINK_CYC < 1)
        $error("bad timing parameter");
    typedef struct packed {
        bridge_pkg::tx_state_e tx_st;
        logic [15:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [11:0] tx_sh;
        logic [7:0] tx_hold;
        logic tx_pend;
        logic rx_busy;
        logic [15:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [8:0] rx_sh;
        logic rx_d;
        logic [31:0] hold_cnt;
        logic powered;
        logic restore;
        logic [31:0] blink_cnt;
        logic blink;
        logic [7:0] fwd_data;
        logic fwd_valid;
        logic cmd;
        logic ms;
        logic [7:0] cmd_byte;
        logic cmd_valid;
        logic txd;
        logic rts_n;
    } st_s;
    st_s r, nxt;
    // fixed frame at reset default; divider fixed at the default rate, elaboration error if above 1 Mbps
    localparam logic [15:0] DIV = 16'(`DEF_DIV);
    localparam logic [3:0] NBITS = 4'd8;
    if (`DEF_DIV < `MIN_DIV)
        $error("rate above 1 Mbps");
    logic rst_any;
    assign rst_any = RESET_IN || !PINS.rst_n;
    logic flow_on;
    assign flow_on = !PINS.flow_en_n;
    always_comb begin
        nxt = r;
        nxt.fwd_valid = 1'b0;
        nxt.cmd_valid = 1'b0;
        nxt.cmd = !PINS.mode_sel;
        nxt.ms = PINS.role_sel;
        // ************************************************************
        // power-up restore qualification
        // ************************************************************
        if (!r.powered)
        begin
            if (!PINS.restore_line)
            begin
                // pin stays an input until the host lets go, so both never drive it during the power-up window
                if (r.hold_cnt == 32'(HOLD_CYC - 1))
                    nxt.restore = 1'b1;
                else
                    nxt.hold_cnt = r.hold_cnt + 32'd1;
            end
            else if (r.hold_cnt != 32'd0)
                nxt.powered = 1'b1; // released after a hold: timer keeps its count, window over
            else
                nxt.powered = 1'b1;
        end
        // ************************************************************
        // radio bytes go out on the uart, dropped in command mode
        // ************************************************************
        if (RADIO_VALID_IN && !r.cmd && !r.tx_pend)
        begin
            nxt.tx_hold = RADIO_DATA_IN;
            nxt.tx_pend = 1'b1;
        end // command mode discards, no buffering
        // ************************************************************
        // transmitter, 8N1
        // ************************************************************
        unique case (r.tx_st)
            bridge_pkg::TX_IDLE:
            begin
                nxt.txd = 1'b1;
                if (r.tx_pend && (!flow_on || !PINS.cts_n))
                begin
                    nxt.tx_sh = {3'b111, r.tx_hold, 1'b0};
                    nxt.tx_pend = 1'b0;
                    nxt.tx_cnt = 16'd0;
                    nxt.tx_bit = 4'd0;
                    nxt.txd = 1'b0;
                    nxt.tx_st = bridge_pkg::TX_SHIFT;
                end
            end
            bridge_pkg::TX_SHIFT:
            begin
                if (r.tx_cnt == DIV - 16'd1)
                begin
                    nxt.tx_cnt = 16'd0;
                    nxt.tx_sh = {1'b1, r.tx_sh[11:1]};
                    nxt.txd = r.tx_sh[1];
                    nxt.tx_bit = r.tx_bit + 4'd1;
                    if (r.tx_bit == NBITS + 4'd1)
                    begin
                        nxt.txd = 1'b1;
                        nxt.tx_st = bridge_pkg::TX_IDLE;
                    end
                end
                else
                    nxt.tx_cnt = r.tx_cnt + 16'd1;
            end
        endcase
        // ************************************************************
        // receiver, mid-bit sampling
        // ************************************************************
        nxt.rx_d = PINS.rxd_dev;
        if (!r.rx_busy)
        begin
            if (!r.rx_d)
            begin
                nxt.rx_busy = 1'b1;
                nxt.rx_cnt = DIV >> 1;
                nxt.rx_bit = 4'd0;
            end
        end
        else if (r.rx_cnt == DIV - 16'd1)
        begin
            nxt.rx_cnt = 16'd0;
            nxt.rx_bit = r.rx_bit + 4'd1;
            nxt.rx_sh = {r.rx_d, r.rx_sh[8:1]};
            // finish on the stop sample so a low last bit is not a new start
            if (r.rx_bit == NBITS + 4'd1)
            begin
                nxt.rx_busy = 1'b0;
                if (r.cmd)
                begin
                    nxt.cmd_byte = r.rx_sh[8:1];
                    nxt.cmd_valid = 1'b1;
                end
                else
                begin
                    nxt.fwd_data = r.rx_sh[8:1];
                    nxt.fwd_valid = 1'b1;
                end
            end
        end
        else
            nxt.rx_cnt = r.rx_cnt + 16'd1;
        // not ready while a forwarded byte is still pending in the holder and flow control is on
        nxt.rts_n = r.tx_pend && flow_on;
        // ************************************************************
        // status led blink timebase
        // ************************************************************
        if (r.blink_cnt == 32'(BLINK_CYC - 1))
        begin
            nxt.blink_cnt = 32'd0;
            nxt.blink = !r.blink;
        end
        else
            nxt.blink_cnt = r.blink_cnt + 32'd1;
    end
    always_ff @(posedge CLK_IN or posedge RESET_IN)
    begin
        if (RESET_IN)
        begin
            r <= '0;
            r.txd <= 1'b1;
            r.rx_d <= 1'b1;
            r.rts_n <= 1'b0;
        end
        else if (!PINS.rst_n)
        begin
            r <= '0;
            r.txd <= 1'b1;
            r.rx_d <= 1'b1;
        end
        else
            r <= nxt;
    end
    logic active;
    assign active = (r.tx_st == bridge_pkg::TX_SHIFT) || r.rx_busy;
    assign PINS.txd_dev = r.txd;
    assign PINS.rts_n = r.rts_n;
    assign PINS.dtr_n = 1'b0;
    assign PINS.tx_active_flag = (r.tx_st == bridge_pkg::TX_SHIFT);
    // on when linked, blinking during traffic or while advertising
    assign PINS.led_n = LINK_UP_IN ? (active & r.blink) : r.blink;
    assign PINS.restore_dev_out = LINK_UP_IN;
    assign PINS.restore_dev_oe_n = !r.powered;
    assign FWD_DATA_OUT = r.fwd_data;
    assign FWD_VALID_OUT = r.fwd_valid;
    assign RESTORE_OUT = r.restore;
    assign CMD_MODE_OUT = r.cmd;
    assign MASTER_SLAVE_OUT = r.ms;
    assign CMD_BYTE_OUT = r.cmd_byte;
    assign CMD_VALID_OUT = r.cmd_valid;
endmodule : uart_bridge_dev
`default_nettype wire

// ===== logic/uart_bridge_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "bridge_cfg.svh"
module uart_bridge_host (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    // pins
    bridge_if.host PINS,
    // control
    input wire logic CMD_MODE_IN,
    input wire logic ROLE_MS_IN,
    input wire logic FLOW_EN_IN,
    input wire logic CHIP_RST_IN,
    input wire logic RESTORE_REQ_IN,
    input wire logic PERMIT_TX_IN,
    output logic LINK_UP_OUT,
    output logic TX_BUSY_OUT
);
    typedef struct packed {
        logic mode;
        logic role;
        logic flow_n;
        logic rst_n;
        logic cts_n;
        logic rest_oe_n;
        logic link;
        logic busy;
    } st_s;
    st_s r, nxt;
    always_comb begin
        nxt = r;
        nxt.mode = !CMD_MODE_IN;
        nxt.role = ROLE_MS_IN;
        nxt.flow_n = !FLOW_EN_IN;
        nxt.rst_n = !CHIP_RST_IN;
        nxt.cts_n = !PERMIT_TX_IN;
        nxt.rest_oe_n = !RESTORE_REQ_IN; // hold low for as long as RESTORE_REQ_IN is asserted
        nxt.link = PINS.restore_line;
        nxt.busy = PINS.tx_active_flag;
    end
    always_ff @(posedge CLK_IN or posedge RESET_IN)
    begin
        if (RESET_IN)
        begin
            r <= '0;
            r.mode <= 1'b1;
            r.role <= 1'b1;
            r.flow_n <= 1'b0;
            r.rst_n <= 1'b1;
            // hold the restore pin low across reset so the device sees it at its first edge
            r.rest_oe_n <= 1'b0;
        end
        else
            r <= nxt;
    end
    assign PINS.mode_sel = r.mode;
    assign PINS.role_sel = r.role;
    assign PINS.flow_en_n = r.flow_n;
    assign PINS.rst_n = r.rst_n;
    assign PINS.cts_n = r.cts_n;
    assign PINS.rxd_dev = 1'b1;
    assign PINS.dsr_n = 1'b1;
    assign PINS.dcd_n = 1'b1;
    assign PINS.ri_n = 1'b1;
    assign PINS.restore_host_out = 1'b0;
    assign PINS.restore_host_oe_n = r.rest_oe_n;
    assign LINK_UP_OUT = r.link;
    assign TX_BUSY_OUT = r.busy;
endmodule : uart_bridge_host
`default_nettype wire

// ===== verif/bridge_props.sv
`timescale 1ns/10ps
`default_nettype none
module bridge_props (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    // watched pins
    input wire logic txd_dev,
    input wire logic cts_n,
    input wire logic dtr_n,
    input wire logic flow_en_n,
    input wire logic rst_n,
    input wire logic tx_active_flag,
    input wire logic restore_dev_oe_n,
    input wire logic restore_line
);
    // ****************************************
    // pin relations
    // ****************************************
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);
    sequence start_bit_s;
        (!txd_dev && tx_active_flag) [*8];
    endsequence
    // three cycles so a synchroniser on cts can excuse a late start
    sequence cts_held_s;
        (!flow_en_n && cts_n && !tx_active_flag) [*3];
    endsequence
    dtr_held_a: assert property (dtr_n == 1'b0)
        else $error("dtr not held active");
    idle_line_a: assert property (!tx_active_flag |-> txd_dev)
        else $error("txd low while not sending");
    start_bit_a: assert property ($fell(txd_dev) |-> start_bit_s)
        else $error("start bit short or flag low");
    flag_hold_a: assert property ($rose(tx_active_flag) |-> tx_active_flag [*8])
        else $error("activity flag glitch");
    stop_high_a: assert property ($fell(tx_active_flag) && rst_n |-> $past(txd_dev))
        else $error("frame ended without stop bit");
    cts_gate_a: assert property (cts_held_s |=> txd_dev)
        else $error("frame started without cts");
    pin_reset_a: assert property (!rst_n |=> txd_dev && !tx_active_flag)
        else $error("reset pin did not idle txd");
    restore_in_a: assert property (restore_dev_oe_n && !restore_line |=> restore_dev_oe_n)
        else $error("restore pin driven while held");
    restore_out_a: assert property (!restore_dev_oe_n && rst_n |=> !restore_dev_oe_n)
        else $error("status pin released");
endmodule : bridge_props
`default_nettype wire

// ===== verif/uart_radio_bridge_pin_control_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "bridge_cfg.svh"
module uart_radio_bridge_pin_control_tb_top;
    // ****************************************
    // harness
    // ****************************************
    logic CLK_IN, RESET_IN, link_up, radio_valid, cmd_mode, role_ms, flow_en;
    logic chip_rst, restore_req, permit_tx, fwd_valid, restore_o, cmd_mode_o;
    logic ms_o, cmd_valid, link_up_o, tx_busy;
    logic [7:0] radio_data, fwd_data, cmd_byte, got;
    int miscompares, samples_checked;
    bridge_if bridge_if_i ();
    // short hold and blink so the restore window fits the run
    uart_bridge_dev #(.HOLD_CYC(100), .BLINK_CYC(10)) uart_bridge_dev_i (
        .CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .PINS(bridge_if_i), .LINK_UP_IN(link_up),
        .RADIO_DATA_IN(radio_data), .RADIO_VALID_IN(radio_valid), .FWD_DATA_OUT(fwd_data),
        .FWD_VALID_OUT(fwd_valid), .RESTORE_OUT(restore_o), .CMD_MODE_OUT(cmd_mode_o),
        .MASTER_SLAVE_OUT(ms_o), .CMD_BYTE_OUT(cmd_byte), .CMD_VALID_OUT(cmd_valid));
    uart_bridge_host uart_bridge_host_i (
        .CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .PINS(bridge_if_i), .CMD_MODE_IN(cmd_mode),
        .ROLE_MS_IN(role_ms), .FLOW_EN_IN(flow_en), .CHIP_RST_IN(chip_rst),
        .RESTORE_REQ_IN(restore_req), .PERMIT_TX_IN(permit_tx), .LINK_UP_OUT(link_up_o),
        .TX_BUSY_OUT(tx_busy));
    bridge_props bridge_props_i (
        .CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .txd_dev(bridge_if_i.txd_dev),
        .cts_n(bridge_if_i.cts_n), .dtr_n(bridge_if_i.dtr_n),
        .flow_en_n(bridge_if_i.flow_en_n), .rst_n(bridge_if_i.rst_n),
        .tx_active_flag(bridge_if_i.tx_active_flag),
        .restore_dev_oe_n(bridge_if_i.restore_dev_oe_n),
        .restore_line(bridge_if_i.restore_line));
    initial
    begin
        CLK_IN = 1'b0;
        forever #4 CLK_IN = ~CLK_IN;
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task cyc(input int n);
        repeat (n) @(posedge CLK_IN);
    endtask : cyc
    task chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task send(input logic [7:0] b);
        @(posedge CLK_IN);
        radio_data <= b;
        radio_valid <= 1'b1;
        @(posedge CLK_IN);
        radio_valid <= 1'b0;
    endtask : send
    // decodes one frame off txd at mid-bit, lsb first
    task rx_frame(output logic [7:0] b);
        int n;
        n = 0;
        b = 8'h00;
        while (bridge_if_i.txd_dev === 1'b1 && n < 20000)
        begin
            @(posedge CLK_IN);
            n++;
        end
        cyc(`DEF_DIV / 2);
        chk(bridge_if_i.txd_dev, 1'b0);
        for (int i = 0; i < 8; i++)
        begin
            cyc(`DEF_DIV);
            b[i] = bridge_if_i.txd_dev;
        end
        cyc(`DEF_DIV);
        chk(bridge_if_i.txd_dev, 1'b1);
    endtask : rx_frame
    task final_report;
        $display("checked=%0d miscompares=%0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    // ****************************************
    // scenarios
    // ****************************************
    task test_restore(input int hold, input logic e);
        RESET_IN <= 1'b1;
        restore_req <= 1'b1;
        cyc(5);
        RESET_IN <= 1'b0;
        cyc(hold);
        restore_req <= 1'b0;
        cyc(20);
        chk(restore_o, e);
        $display("test restore %0d done", hold);
    endtask : test_restore
    task test_link;
        link_up <= 1'b1;
        cyc(10);
        chk(link_up_o, 1'b1);
        chk(bridge_if_i.led_n, 1'b0);
        link_up <= 1'b0;
        cyc(10);
        chk(link_up_o, 1'b0);
        $display("test link done");
    endtask : test_link
    task test_modes;
        for (int r = 0; r < 2; r++)
        begin
            role_ms <= r[0];
            cmd_mode <= r[0];
            cyc(10);
            chk(ms_o, r[0]);
            chk(cmd_mode_o, r[0]);
        end
        send(8'h55);
        cyc(100);
        chk(bridge_if_i.tx_active_flag, 1'b0);
        cmd_mode <= 1'b0;
        cyc(10);
        $display("test modes done");
    endtask : test_modes
    task test_flow;
        permit_tx <= 1'b0;
        cyc(5);
        send(8'h3C);
        cyc(200);
        chk(bridge_if_i.txd_dev, 1'b1);
        chk(bridge_if_i.rts_n, 1'b1);
        permit_tx <= 1'b1;
        rx_frame(got);
        chk(got, 8'h3C);
        flow_en <= 1'b0;
        permit_tx <= 1'b0;
        send(8'hC3);
        rx_frame(got);
        chk(got, 8'hC3);
        flow_en <= 1'b1;
        permit_tx <= 1'b1;
        $display("test flow done");
    endtask : test_flow
    task test_chip_reset;
        send(8'h0F);
        cyc(3000);
        chk(bridge_if_i.tx_active_flag, 1'b1);
        chip_rst <= 1'b1;
        cyc(5);
        chk(bridge_if_i.txd_dev, 1'b1);
        chip_rst <= 1'b0;
        cyc(10);
        $display("test chip reset done");
    endtask : test_chip_reset
    initial
    begin
        {RESET_IN, link_up, radio_valid, cmd_mode, role_ms, chip_rst} = 6'h20;
        {restore_req, permit_tx, flow_en, radio_data} = 11'h300;
        miscompares = 0;
        samples_checked = 0;
        test_restore(50, 1'b0);
        test_restore(150, 1'b1);
        test_link();
        test_modes();
        test_flow();
        test_chip_reset();
        final_report();
    end
    initial
    begin
        cyc(90000);
        miscompares++;
        final_report();
    end
endmodule : uart_radio_bridge_pin_control_tb_top
`default_nettype wire
